/* rtl/smc_consts.svh */
// constants of the sleep mode controller: offsets, fields, encodings, timing
// assumes a 100 MHz core clock and an 8-bit register path from the core
// Operation
// - sleep only with arm bit set on halt
// - interrupt wake: start-up, four stall cycles, handler
// - register file and memory kept across sleep
// - reset in sleep restarts at reset vector
// - droop monitor off in deep sleep, on at wake
// - monitor-off wake takes about 60 us
// - sleep-off bit one disables monitor, reset zero
// - sleep-off bit written only by timed sequence; a plain write of zero clears it
// - mode 000 idle: core and flash clocks stop
// - mode 001 converter noise reduction clock set
// - converter enabled: conversion starts on entry
// - noise reduction mode limited wake sources
// - mode 010 power-down: all generated clocks stop
// - power-down limited wake sources
// - level wake must last through start-up
// - power-down wake waits clock restart time
// - external pins wake deep modes by level only
// - mode 011 power-save keeps timer 2 waking
// - power-save oscillators follow timer 2 clocking
// - prefer power-down when timer 2 idle
// - comparator off in idle if not needed
// - mode 110 standby, oscillator runs, six cycles
// - mode 111 extended standby, six cycle wake
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
`define SMC_ADDR_SLEEP_CTRL 8'h53
`define SMC_ADDR_MCU_CTRL 8'h55
`define SMC_SLEEP_CTRL_RST 4'h0
`define SMC_BROWNOUT_SLEEP_OFF_BIT 6
`define SMC_BODSE_BIT 5
`define SMC_MODE_IDLE 3'h0
`define SMC_MODE_ADC 3'h1
`define SMC_MODE_PDOWN 3'h2
`define SMC_MODE_PSAVE 3'h3
`define SMC_MODE_RSV4 3'h4
`define SMC_MODE_RSV5 3'h5
`define SMC_MODE_STBY 3'h6
`define SMC_MODE_XSTBY 3'h7
`define SMC_CLK_MHZ 100
`define SMC_DROOP_WAKE_US 60
`define SMC_DROOP_WAKE_CYC (`SMC_DROOP_WAKE_US * `SMC_CLK_MHZ)
`define SMC_RESTART_CYC 16
`define SMC_HALT_EXTRA 3'h4
`define SMC_STBY_WAKE 16'h0006
`define SMC_SEQ_WINDOW 3'h4
`endif

/* rtl/smc_core.sv */
// core end of the sleep link: halt opcode, register writes, timed sequence
// assumes user requests are synchronous to core_clk_i
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_core import smc_pkg::*; (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  smc_if.core bus,
  input wire logic halt_req_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic brownout_sleep_off_seq_i,
  input wire logic timer2_running_i,
  input wire logic cmp_wake_needed_i,
  output logic [7:0] rdata_o,
  output logic busy_o,
  output logic sleeping_o,
  output logic irq_handler_o,
  output logic reset_vector_o,
  output logic resumed_o,
  output logic comparator_off_o
);

  smc_core_t r;
  smc_core_t next_r;

  // next state: sequence first, then user writes, halt when idle
  always_comb begin
    next_r = r;
    next_r.exec = 1'b0;
    next_r.wr = 1'b0;
    next_r.addr = addr_i;
    next_r.wdata = wdata_i;
    next_r.rdata = bus.reg_rdata;
    case (r.state)
      SMC_C_IDLE: begin
        if (brownout_sleep_off_seq_i && !bus.core_stall) begin
          next_r.state = SMC_C_SEQ1;
        end else if (wr_i && !bus.core_stall) begin
          next_r.wr = 1'b1;
          if (addr_i == `SMC_ADDR_SLEEP_CTRL && wdata_i[3:1] == `SMC_MODE_PSAVE &&
              !timer2_running_i) begin
            next_r.wdata = {wdata_i[7:4], `SMC_MODE_PDOWN, wdata_i[0]};
          end
          if (addr_i == `SMC_ADDR_SLEEP_CTRL) begin
            next_r.kind = next_r.wdata[3:1];
          end
        end else if (halt_req_i && !bus.core_stall) begin
          // halt opcode issued only while running
          next_r.exec = 1'b1;
        end
      end
      SMC_C_SEQ1: begin
        next_r.wr = 1'b1;
        next_r.addr = `SMC_ADDR_MCU_CTRL;
        next_r.wdata = 8'h00;
        next_r.wdata[`SMC_BROWNOUT_SLEEP_OFF_BIT] = 1'b1;
        next_r.wdata[`SMC_BODSE_BIT] = 1'b1;
        next_r.state = SMC_C_SEQ2;
      end
      SMC_C_SEQ2: begin
        next_r.wr = 1'b1;
        next_r.addr = `SMC_ADDR_MCU_CTRL;
        next_r.wdata = 8'h00;
        next_r.wdata[`SMC_BROWNOUT_SLEEP_OFF_BIT] = 1'b1;
        next_r.state = SMC_C_IDLE;
      end
      default: next_r.state = SMC_C_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
      r.state <= SMC_C_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // link drive and user status
  assign bus.sleep_exec = r.exec;
  assign bus.reg_wr = r.wr;
  assign bus.reg_addr = r.addr;
  assign bus.reg_wdata = r.wdata;
  assign rdata_o = r.rdata;
  assign busy_o = r.state != SMC_C_IDLE;
  assign sleeping_o = bus.core_stall;
  assign irq_handler_o = bus.irq_take;
  assign reset_vector_o = bus.rst_vec;
  assign resumed_o = bus.resume;
  // comparator off when idle wake unneeded
  assign comparator_off_o = r.kind == `SMC_MODE_IDLE && !cmp_wake_needed_i;

endmodule

/* rtl/smc_device.sv */
// sleep mode controller: clock gating, wake sources, wake timing, monitor off
// assumes wake and reset inputs already synchronous to core_clk_i
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_device import smc_pkg::*; #(
  parameter int unsigned RESTART_CYC = `SMC_RESTART_CYC,
  parameter int unsigned DROOP_CYC = `SMC_DROOP_WAKE_CYC
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  smc_if.dev bus,
  input wire logic crystal_clk_i,
  input wire logic timer2_en_i,
  input wire logic timer2_async_i,
  input wire logic timer2_sync_i,
  input wire logic [1:0] timer2_irq_mask_i,
  input wire logic timer2_ovf_i,
  input wire logic timer2_cmp_i,
  input wire logic global_irq_en_i,
  input wire logic adc_enabled_i,
  input wire logic adc_done_i,
  input wire logic ext_level_irq_i,
  input wire logic ext_edge_irq_i,
  input wire logic pin_change_i,
  input wire logic twi_match_i,
  input wire logic wdt_irq_i,
  input wire logic spm_ready_i,
  input wire logic other_io_irq_i,
  input wire logic ext_rst_i,
  input wire logic wdt_rst_i,
  input wire logic bor_rst_i,
  output logic core_clk_en_o,
  output logic flash_clk_en_o,
  output logic io_clk_en_o,
  output logic adc_clk_en_o,
  output logic asy_clk_en_o,
  output logic main_osc_en_o,
  output logic timer_osc_en_o,
  output logic droop_monitor_en_o,
  output logic adc_start_o,
  output logic mem_retain_o
);

  smc_dev_t r;
  smc_dev_t next_r;
  logic t2_wake;
  logic common_wake;
  logic any_rst;
  logic wake;
  logic lvl_alone;
  logic [2:0] eff_mode;

  // clock enables for a mode while asleep
  function automatic smc_gates_t sleep_gates(input logic [2:0] m, input logic ta,
                                              input logic ts);
    smc_gates_t g;
    g = 7'h00;
    case (m)
      `SMC_MODE_IDLE: g = {ta, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      `SMC_MODE_ADC: g = {ta, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      `SMC_MODE_PDOWN: g = 7'h00;
      `SMC_MODE_PSAVE: g = {ta, ts, ta, 1'b0, 1'b0, 1'b0, 1'b0};
      `SMC_MODE_STBY: g = {1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      `SMC_MODE_XSTBY: g = {ta, 1'b1, ta, 1'b0, 1'b0, 1'b0, 1'b0};
      default: g = 7'h7f;
    endcase
    return g;
  endfunction

  // start-up cycles before the halt stretch
  function automatic logic [15:0] start_delay(input logic [2:0] m, input logic off);
    logic [15:0] d;
    d = 16'h0000;
    case (m)
      `SMC_MODE_PDOWN, `SMC_MODE_PSAVE: d = 16'(RESTART_CYC);
      `SMC_MODE_STBY, `SMC_MODE_XSTBY: d = `SMC_STBY_WAKE;
      default: d = 16'h0000;
    endcase
    if (off && d < 16'(DROOP_CYC)) begin
      d = 16'(DROOP_CYC);
    end
    return d;
  endfunction

  // wake source qualification per mode
  always_comb begin
    // timer 2 wake needs mask and global enable
    t2_wake = timer2_en_i && global_irq_en_i &&
              ((timer2_ovf_i && timer2_irq_mask_i[0]) ||
               (timer2_cmp_i && timer2_irq_mask_i[1]));
    // asynchronous sources of the deep modes
    common_wake = ext_level_irq_i || pin_change_i || twi_match_i || wdt_irq_i;
    any_rst = ext_rst_i || wdt_rst_i || bor_rst_i;
    lvl_alone = ext_level_irq_i && !pin_change_i && !twi_match_i && !wdt_irq_i;
    case (r.mode)
      // edge triggered pins wake idle only
      `SMC_MODE_IDLE: wake = common_wake || ext_edge_irq_i || t2_wake || adc_done_i ||
                             spm_ready_i || other_io_irq_i;
      `SMC_MODE_ADC: wake = common_wake || adc_done_i || spm_ready_i ||
                            (t2_wake && timer2_async_i);
      `SMC_MODE_PSAVE, `SMC_MODE_XSTBY: wake = common_wake || t2_wake;
      default: wake = common_wake;
    endcase
  end

  // standby without crystal falls back to the deep mode it extends
  always_comb begin
    eff_mode = r.kind;
    if (!crystal_clk_i && r.kind == `SMC_MODE_STBY) begin
      eff_mode = `SMC_MODE_PDOWN;
    end
    if (!crystal_clk_i && r.kind == `SMC_MODE_XSTBY) begin
      eff_mode = `SMC_MODE_PSAVE;
    end
  end

  // next state of the whole controller
  always_comb begin
    next_r = r;
    next_r.adc_start = 1'b0;
    next_r.irq_take = 1'b0;
    next_r.resume = 1'b0;
    next_r.rst_vec = 1'b0;
    if (r.win != 3'h0) begin
      next_r.win = r.win - 3'h1;
    end
    if (bus.reg_wr && bus.reg_addr == `SMC_ADDR_SLEEP_CTRL) begin
      next_r.kind = bus.reg_wdata[3:1];
      next_r.arm = bus.reg_wdata[0];
    end
    if (bus.reg_wr && bus.reg_addr == `SMC_ADDR_MCU_CTRL) begin
      if (bus.reg_wdata[`SMC_BODSE_BIT] && bus.reg_wdata[`SMC_BROWNOUT_SLEEP_OFF_BIT]) begin
        next_r.win = `SMC_SEQ_WINDOW;
      end else if (r.win != 3'h0 && bus.reg_wdata[`SMC_BROWNOUT_SLEEP_OFF_BIT]) begin
        next_r.brownout_sleep_off = 1'b1;
        next_r.win = 3'h0;
      end else if (!bus.reg_wdata[`SMC_BROWNOUT_SLEEP_OFF_BIT]) begin
        next_r.brownout_sleep_off = 1'b0;
      end
    end
    case (r.state)
      SMC_RUN: begin
        // armed halt enters the selected mode
        if (bus.sleep_exec && r.arm && eff_mode != `SMC_MODE_RSV4 &&
            eff_mode != `SMC_MODE_RSV5) begin
          next_r.state = SMC_SLEEP;
          next_r.mode = eff_mode;
          // monitor off only in the deep modes
          next_r.bod_off = r.brownout_sleep_off && eff_mode != `SMC_MODE_IDLE &&
                           eff_mode != `SMC_MODE_ADC;
          next_r.gates = sleep_gates(eff_mode, timer2_async_i, timer2_sync_i);
          next_r.adc_start = adc_enabled_i && eff_mode == `SMC_MODE_ADC;
          next_r.droop_en = !next_r.bod_off;
        end
      end
      SMC_SLEEP: begin
        if (any_rst || wake) begin
          next_r.state = SMC_START;
          next_r.cnt = start_delay(r.mode, r.bod_off);
          next_r.rst_pend = any_rst;
          next_r.irq_pend = wake;
          next_r.lvl_only = lvl_alone;
          next_r.gates = 7'h7f;
          next_r.droop_en = 1'b1;
        end
      end
      SMC_START: begin
        if (any_rst) begin
          next_r.rst_pend = 1'b1;
        end
        if (r.cnt == 16'h0000) begin
          next_r.state = SMC_HALT;
          next_r.cnt = 16'({13'h0000, `SMC_HALT_EXTRA - 3'h1});
          if (r.lvl_only && !ext_level_irq_i) begin
            next_r.irq_pend = 1'b0;
          end
        end else begin
          next_r.cnt = r.cnt - 16'h0001;
        end
      end
      SMC_HALT: begin
        if (any_rst) begin
          next_r.rst_pend = 1'b1;
        end
        if (r.cnt == 16'h0000) begin
          next_r.state = SMC_RUN;
          next_r.bod_off = 1'b0;
          next_r.rst_vec = r.rst_pend || any_rst;
          next_r.irq_take = r.irq_pend && !(r.rst_pend || any_rst);
          next_r.resume = !(r.rst_pend || any_rst);
          next_r.rst_pend = 1'b0;
          next_r.irq_pend = 1'b0;
        end else begin
          next_r.cnt = r.cnt - 16'h0001;
        end
      end
      default: next_r.state = SMC_RUN;
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
      r.state <= SMC_RUN;
      r.gates <= 7'h7f;
      r.droop_en <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // register read path, unmapped reads give zero
  always_comb begin
    case (bus.reg_addr)
      `SMC_ADDR_SLEEP_CTRL: bus.reg_rdata = {4'h0, r.kind, r.arm};
      `SMC_ADDR_MCU_CTRL: bus.reg_rdata = {1'b0, r.brownout_sleep_off, r.win != 3'h0, 5'h00};
      default: bus.reg_rdata = 8'h00;
    endcase
  end

  // outputs straight from the state record
  assign bus.core_stall = r.state != SMC_RUN;
  assign bus.irq_take = r.irq_take;
  assign bus.resume = r.resume;
  assign bus.rst_vec = r.rst_vec;
  assign {timer_osc_en_o, main_osc_en_o, asy_clk_en_o, adc_clk_en_o, io_clk_en_o,
          flash_clk_en_o, core_clk_en_o} = r.gates;
  assign droop_monitor_en_o = r.droop_en;
  assign adc_start_o = r.adc_start;
  assign mem_retain_o = r.state != SMC_RUN;

endmodule

/* rtl/smc_if.sv */
// link between the processor core and the sleep mode controller
// assumes both ends share one clock
`timescale 1ns/1ps
interface smc_if;
  logic sleep_exec;
  logic reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic core_stall;
  logic irq_take;
  logic resume;
  logic rst_vec;
  modport dev (input sleep_exec, reg_wr, reg_addr, reg_wdata,
    output reg_rdata, core_stall, irq_take, resume, rst_vec);
  modport core (output sleep_exec, reg_wr, reg_addr, reg_wdata,
    input reg_rdata, core_stall, irq_take, resume, rst_vec);
endinterface

/* rtl/smc_pkg.sv */
// types of the sleep mode controller: states and register state records
// assumes smc_consts.svh is on the include path
package smc_pkg;
  typedef enum logic [1:0] {SMC_RUN, SMC_SLEEP, SMC_START, SMC_HALT} smc_state_t;
  typedef enum logic [1:0] {SMC_C_IDLE, SMC_C_SEQ1, SMC_C_SEQ2} smc_cstate_t;
  // clock enables: timer osc, main osc, async, adc, io, flash, core
  typedef logic [6:0] smc_gates_t;
  typedef struct packed {
    smc_state_t state;
    logic [2:0] kind;
    logic arm;
    logic brownout_sleep_off;
    logic [2:0] win;
    logic [2:0] mode;
    logic bod_off;
    logic [15:0] cnt;
    logic irq_pend;
    logic lvl_only;
    logic rst_pend;
    smc_gates_t gates;
    logic droop_en;
    logic adc_start;
    logic irq_take;
    logic resume;
    logic rst_vec;
  } smc_dev_t;
  typedef struct packed {
    smc_cstate_t state;
    logic exec;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [2:0] kind;
  } smc_core_t;
endpackage

/* testbench/sleep_mode_controller_bench.sv */
// self-checking bench: core end and controller end joined by the link
// assumes small restart and monitor wake counts set here
`timescale 1ns/1ps
`include "smc_consts.svh"
module sleep_mode_controller_bench import smc_pkg::*;;
  logic core_clk_i = 0, resetn_i = 0, halt_req_i = 0, wr_i = 0, brownout_sleep_off_seq_i = 0;
  logic adc_enabled_i = 0, timer2_running_i = 1, cmp_wake_needed_i = 1;
  logic crystal_clk_i = 1, global_irq_en_i = 1, timer2_async_i = 1;
  logic [7:0] addr_i = 0, wdata_i = 0, rdata_o;
  logic [12:0] src = 0;
  logic [4:0] dom_en;
  logic core_clk_en_o, flash_clk_en_o, io_clk_en_o, adc_clk_en_o, main_osc_en_o;
  logic asy_clk_en_o, timer_osc_en_o, droop_monitor_en_o, adc_start_o, mem_retain_o;
  logic busy_o, sleeping_o, irq_handler_o, reset_vector_o, resumed_o, comparator_off_o;
  int num_errors = 0, n_tests = 0, n_starts = 0;

  smc_if bif();
  smc_core i_smc_core (.core_clk_i, .resetn_i, .bus(bif), .halt_req_i, .wr_i, .addr_i,
    .wdata_i, .brownout_sleep_off_seq_i, .timer2_running_i, .cmp_wake_needed_i, .rdata_o,
    .busy_o, .sleeping_o, .irq_handler_o, .reset_vector_o, .resumed_o,
    .comparator_off_o);
  smc_device #(.RESTART_CYC(8), .DROOP_CYC(20)) i_smc_device (.core_clk_i, .resetn_i,
    .bus(bif), .crystal_clk_i, .timer2_en_i(1'b1), .timer2_async_i,
    .timer2_sync_i(1'b0), .timer2_irq_mask_i(2'h3), .timer2_ovf_i(src[6]),
    .timer2_cmp_i(src[9]), .global_irq_en_i, .adc_enabled_i, .adc_done_i(src[4]),
    .ext_level_irq_i(src[1]), .ext_edge_irq_i(src[10]), .pin_change_i(src[5]),
    .twi_match_i(src[7]), .wdt_irq_i(src[0]), .spm_ready_i(src[8]),
    .other_io_irq_i(src[3]), .ext_rst_i(src[2]), .wdt_rst_i(src[11]), .bor_rst_i(src[12]),
    .core_clk_en_o, .flash_clk_en_o, .io_clk_en_o, .adc_clk_en_o, .asy_clk_en_o,
    .main_osc_en_o, .timer_osc_en_o, .droop_monitor_en_o, .adc_start_o, .mem_retain_o);
  smc_link_properties i_smc_link_properties (.core_clk_i, .resetn_i,
    .sleep_exec(bif.sleep_exec), .reg_wr(bif.reg_wr), .core_stall(bif.core_stall),
    .irq_take(bif.irq_take), .resume(bif.resume), .rst_vec(bif.rst_vec));

  // clock and a count of conversion starts
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (adc_start_o) n_starts <= n_starts + 1;

  // clock domains compared per mode: core, flash, io, converter, main oscillator
  assign dom_en = {core_clk_en_o, flash_clk_en_o, io_clk_en_o, adc_clk_en_o, main_osc_en_o};

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick;
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    tick;
    wr_i <= 0;
    tick(2);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    tick;
    addr_i <= a;
    tick(3);
    #1 chk(rdata_o, e);
  endtask

  task automatic halt(input logic ok);
    tick;
    halt_req_i <= 1;
    tick;
    halt_req_i <= 0;
    tick(2);
    #1 chk(bif.core_stall, ok);
    chk(sleeping_o, ok);
    chk(mem_retain_o, ok);
  endtask

  task automatic enter(input logic [2:0] k, input logic ok);
    wr(`SMC_ADDR_SLEEP_CTRL, {4'h0, k, 1'b1});
    halt(ok);
  endtask

  // raise one wake source for a cycle and time the outcome
  task automatic wake(input int s, input int d, input logic irq);
    int n;
    n = 0;
    tick;
    src[s] <= 1;
    do begin
      tick;
      n++;
      if (n == 1) src <= 0;
      #1;
    end while (!(resumed_o || reset_vector_o) && n < 200);
    chk(8'(n), 8'(d + 6));
    chk(irq_handler_o, irq);
    chk(reset_vector_o, s == 2 || s > 10);
    chk(resumed_o, !(s == 2 || s > 10));
    chk(mem_retain_o, 0);
    chk(droop_monitor_en_o, 1);
  endtask

  task automatic t_regs();
    chk(droop_monitor_en_o, 1);
    rd(`SMC_ADDR_MCU_CTRL, 8'h00);
    rd(8'h10, 8'h00);
    wr(`SMC_ADDR_SLEEP_CTRL, 8'h0c);
    rd(`SMC_ADDR_SLEEP_CTRL, 8'h0c);
    halt(0);
    enter(3'h4, 0);
  endtask

  // every mode: gates in sleep, then a wake from a source it allows
  task automatic t_modes();
    int k[6] = '{0, 1, 2, 3, 6, 7};
    int s[6] = '{3, 4, 5, 6, 7, 11};
    int d[6] = '{0, 0, 8, 8, 6, 6};
    logic [4:0] g[6] = '{5'h07, 5'h03, 5'h00, 5'h00, 5'h01, 5'h01};
    for (int i = 0; i < 6; i++) begin
      enter(3'(k[i]), 1);
      chk(dom_en, g[i]);
      wake(s[i], d[i], s[i] != 11);
    end
  endtask

  // sources that the deep mode must ignore, then a supply reset
  task automatic t_refuse();
    enter(3'h2, 1);
    tick;
    src <= 13'h0758;
    tick(12);
    src <= 0;
    #1 chk(bif.core_stall, 1);
    wake(12, 8, 0);
  endtask

  // conversion start on noise reduction entry only, and a vanished level
  task automatic t_misc();
    int s0;
    tick;
    adc_enabled_i <= 1;
    s0 = n_starts;
    enter(3'h1, 1);
    chk(8'(n_starts - s0), 8'h01);
    wake(0, 0, 1);
    s0 = n_starts;
    enter(3'h2, 1);
    chk(8'(n_starts - s0), 8'h00);
    wake(1, 8, 0);
    tick;
    adc_enabled_i <= 0;
  endtask

  task automatic t_brownout_sleep_off();
    wr(`SMC_ADDR_MCU_CTRL, 8'h40);
    rd(`SMC_ADDR_MCU_CTRL, 8'h00);
    tick;
    brownout_sleep_off_seq_i <= 1;
    tick;
    brownout_sleep_off_seq_i <= 0;
    #1 chk(busy_o, 1);
    tick(6);
    rd(`SMC_ADDR_MCU_CTRL, 8'h40);
    enter(3'h2, 1);
    chk(droop_monitor_en_o, 0);
    wake(0, 20, 1);
    wr(`SMC_ADDR_MCU_CTRL, 8'h00);
    rd(`SMC_ADDR_MCU_CTRL, 8'h00);
  endtask

  // core-side choices and the inputs that shape entry and wake-up
  task automatic t_inputs();
    wr(`SMC_ADDR_SLEEP_CTRL, 8'h00);
    cmp_wake_needed_i <= 0;
    #1 chk(comparator_off_o, 1);
    tick;
    cmp_wake_needed_i <= 1;
    timer2_running_i <= 0;
    #1 chk(comparator_off_o, 0);
    wr(`SMC_ADDR_SLEEP_CTRL, 8'h07);
    rd(`SMC_ADDR_SLEEP_CTRL, 8'h05);
    tick;
    timer2_running_i <= 1;
    crystal_clk_i <= 0;
    enter(3'h6, 1);
    chk(dom_en, 5'h00);
    wake(5, 8, 1);
    tick;
    crystal_clk_i <= 1;
    enter(3'h3, 1);
    chk({timer_osc_en_o, asy_clk_en_o}, 2'h3);
    tick;
    global_irq_en_i <= 0;
    src[6] <= 1;
    tick(4);
    src <= 0;
    global_irq_en_i <= 1;
    #1 chk(bif.core_stall, 1);
    wake(6, 8, 1);
    tick;
    timer2_async_i <= 0;
    enter(3'h1, 1);
    chk({timer_osc_en_o, asy_clk_en_o}, 2'h1);
    tick;
    src[6] <= 1;
    tick(4);
    src <= 0;
    #1 chk(bif.core_stall, 1);
    wake(4, 0, 1);
    tick;
    timer2_async_i <= 1;
  endtask

  task automatic finish_test();
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // main sequence after 20 cycles of reset
  initial begin
    tick(20);
    resetn_i <= 1;
    t_regs;
    t_modes;
    t_refuse;
    t_misc;
    t_brownout_sleep_off;
    t_inputs;
    finish_test;
  end

  // watchdog well beyond the expected few hundred cycles
  initial begin
    #200us;
    num_errors++;
    finish_test;
  end
endmodule

/* testbench/smc_link_properties.sv */
// checker of the sleep link between the core end and the controller end
// assumes the link signals are fed in plainly, all on core_clk_i
`timescale 1ns/1ps
module smc_link_properties (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic sleep_exec,
  input wire logic reg_wr,
  input wire logic core_stall,
  input wire logic irq_take,
  input wire logic resume,
  input wire logic rst_vec
);
  // one clock domain, reset low disables all checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  // sleep entry, quiet link, wake outcome and its timing
  stall_entry_a: assert property ($rose(core_stall) |-> $past(sleep_exec))
    else $error("stall began without a halt");
  quiet_stall_a: assert property (core_stall |-> !reg_wr && !sleep_exec)
    else $error("request issued while stalled");
  irq_resume_a: assert property (irq_take |-> resume)
    else $error("handler start without resume");
  halt_span_a: assert property (resume |-> $past(core_stall, 5) && $past(core_stall))
    else $error("resume before start-up and halt");
  stall_release_a: assert property ($fell(core_stall) |-> resume || rst_vec)
    else $error("stall dropped with no outcome");
  wake_exclusive_a: assert property (!(resume && rst_vec))
    else $error("resume and restart together");
  pulse_single_a: assert property ((resume || rst_vec) |=> !resume && !rst_vec)
    else $error("wake pulse longer than one cycle");
  release_cause_a: assert property ((resume || rst_vec) |-> !core_stall && $past(core_stall))
    else $error("wake pulse outside stall release");
endmodule
